/* logic/osc_ctrl_defines.svh */
`ifndef OSC_CTRL_DEFINES_SVH
`define OSC_CTRL_DEFINES_SVH

// Register indices; byte address is four times the index
`define OSC_IDX_W         12
`define OSC_PWR_IDX       12'hED5
`define OSC_STATUS_IDX    12'hED6
`define OSC_ENABLE_IDX    12'hED7
`define OSC_TUNE_IDX      12'hED8
`define OSC_FREQ_IDX      12'hED9
`define OSC_IRQ_STAT_IDX  12'hEDA
`define OSC_IRQ_MASK_IDX  12'hEDB

// Bit positions shared by status, event and mask registers, and by enable except OSC_PLL_BIT; OSC_SEC_PWR_BIT is in the power register
`define OSC_EXT_BIT   7
`define OSC_HF_BIT    6
`define OSC_MF_BIT    5
`define OSC_LF_BIT    4
`define OSC_SEC_BIT   3
`define OSC_CONV_BIT  2
`define OSC_PLL_BIT   0
`define OSC_SEC_PWR_BIT 6

// Field widths and codes
`define OSC_FREQ_W      4
`define OSC_FREQ_MAX    4'h8
`define OSC_FREQ_RESET  4'h2
`define OSC_TRIM_W      6
`define OSC_TRIM_RESET  6'h00
`define OSC_ENABLE_RESET 8'h00
`define OSC_ENABLE_MASK  8'hFC
`define OSC_EVENT_MASK   8'hFD
`define OSC_HSIZE_WORD  3'h2
`define OSC_HTRANS_NONSEQ 2'h2

`endif

/* logic/osc_ctrl_pkg.sv */
package osc_ctrl_pkg;

  typedef enum logic [1:0] {
    dp_none  = 2'b00,
    dp_write = 2'b01,
    dp_read  = 2'b10
  } dphase_t;

  typedef logic [7:0] osc_byte_t;

endpackage

/* logic/osc_sync2.sv */
`timescale 1ns/100ps

module osc_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Asynchronous levels in, synchronous levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;

  initial begin
    if (W < 1) $error("osc_sync2: W must be at least 1");
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule

/* logic/osc_sticky_flags.sv */
`timescale 1ns/100ps

module osc_sticky_flags #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Event set and write-one clear
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // Flag state
  output logic      [W-1:0] flags,
  output logic      [W-1:0] next_flags
);

  initial begin
    if (W < 1) $error("osc_sticky_flags: W must be at least 1");
  end

  // A set in the clearing cycle wins
  always_comb begin
    next_flags = (flags & ~clr) | set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

/* logic/osc_ready_enable_freq_ctrl.sv */
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "osc_ctrl_defines.svh"

module osc_ready_enable_freq_ctrl
  import osc_ctrl_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int MODE_W = 3
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Oscillator ready levels, asynchronous
  input  wire logic              ext_osc_ready_raw,
  input  wire logic              hf_int_ready_raw,
  input  wire logic              mf_int_ready_raw,
  input  wire logic              lf_int_ready_raw,
  input  wire logic              secondary_ready_raw,
  input  wire logic              converter_ready_raw,
  input  wire logic              pll_lock_raw,
  // Peripheral requests and configuration
  input  wire logic              ext_osc_req,
  input  wire logic              hf_int_req,
  input  wire logic              mf_int_req,
  input  wire logic              lf_int_req,
  input  wire logic              secondary_req,
  input  wire logic              converter_osc_req,
  input  wire logic              pll_enable,
  input  wire logic [MODE_W-1:0] ext_osc_mode_config,
  // Oscillator controls
  output logic                   ext_osc_run,
  output logic                   hf_int_run,
  output logic                   mf_int_run,
  output logic                   lf_int_run,
  output logic                   secondary_run,
  output logic                   converter_osc_run,
  output logic      [MODE_W-1:0] ext_osc_mode,
  output logic                   secondary_power_select,
  output logic [`OSC_FREQ_W-1:0] hf_freq_code,
  output logic [`OSC_TRIM_W-1:0] hf_trim_code,
  // Interrupt
  output logic                   irq
);

  localparam int IW = ADDR_W - 2;

  localparam logic [IW-1:0] I_PWR  = IW'(`OSC_PWR_IDX);
  localparam logic [IW-1:0] I_STAT = IW'(`OSC_STATUS_IDX);
  localparam logic [IW-1:0] I_EN   = IW'(`OSC_ENABLE_IDX);
  localparam logic [IW-1:0] I_TUNE = IW'(`OSC_TUNE_IDX);
  localparam logic [IW-1:0] I_FREQ = IW'(`OSC_FREQ_IDX);
  localparam logic [IW-1:0] I_ISTS = IW'(`OSC_IRQ_STAT_IDX);
  localparam logic [IW-1:0] I_IMSK = IW'(`OSC_IRQ_MASK_IDX);

  // The word index must hold the largest register index
  initial begin
    if (ADDR_W < `OSC_IDX_W + 3) begin
      $error("osc_ready_enable_freq_ctrl: ADDR_W too small");
    end
    if (MODE_W < 1) begin
      $error("osc_ready_enable_freq_ctrl: MODE_W must be at least 1");
    end
  end

  // Synchronised ready levels
  logic [6:0] raw_vec;
  logic [6:0] rdy_s;

  assign raw_vec = {
    ext_osc_ready_raw,
    hf_int_ready_raw,
    mf_int_ready_raw,
    lf_int_ready_raw,
    secondary_ready_raw,
    converter_ready_raw,
    pll_lock_raw
  };

  // Ready levels come from other clock domains; two flops before any use
  osc_sync2 #(
    .W (7)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (raw_vec),
    .q       (rdy_s)
  );

  // Bus state
  dphase_t                dphase;
  dphase_t                next_dphase;
  logic [IW-1:0]          dp_idx;
  logic [IW-1:0]          next_dp_idx;
  logic [31:0]            next_hrdata;
  logic                   aphase;
  logic [IW-1:0]          a_idx;
  logic                   wr;
  logic [31:0]            rd_word;
  logic                   next_hreadyout;
  logic                   next_hresp;

  // Control and status state
  osc_byte_t              force_on;
  osc_byte_t              next_force_on;
  logic [`OSC_FREQ_W-1:0] next_freq;
  logic [`OSC_TRIM_W-1:0] next_trim;
  logic                   next_pwr;
  osc_byte_t              irq_mask;
  osc_byte_t              next_irq_mask;
  osc_byte_t              status;
  osc_byte_t              next_status;
  osc_byte_t              irq_clr;
  osc_byte_t              irq_set;
  osc_byte_t              irq_flags;
  osc_byte_t              next_irq_flags;
  logic                   next_irq;
  logic                   next_ext_run;
  logic                   next_hf_run;
  logic                   next_mf_run;
  logic                   next_lf_run;
  logic                   next_sec_run;
  logic                   next_conv_run;
  logic [MODE_W-1:0]      next_mode;

  assign aphase = hsel && hready && (htrans == `OSC_HTRANS_NONSEQ);
  assign a_idx  = haddr[ADDR_W-1:2];
  assign wr     = (dphase == dp_write);

  // Software-written registers
  always_comb begin
    next_force_on = force_on;
    next_freq     = hf_freq_code;
    next_trim     = hf_trim_code;
    next_pwr      = secondary_power_select;
    next_irq_mask = irq_mask;
    irq_clr       = '0;
    if (wr) begin
      case (dp_idx)
        I_EN: begin
          next_force_on = hwdata[7:0] & `OSC_ENABLE_MASK;
        end
        I_STAT: begin
          next_force_on = force_on;
        end
        I_FREQ: begin
          // Reserved codes leave the register as it was
          if (hwdata[`OSC_FREQ_W-1:0] <= `OSC_FREQ_MAX) begin
            next_freq = hwdata[`OSC_FREQ_W-1:0];
          end
        end
        I_TUNE: begin
          next_trim = hwdata[`OSC_TRIM_W-1:0];
        end
        I_PWR: begin
          next_pwr = hwdata[`OSC_SEC_PWR_BIT];
        end
        I_IMSK: begin
          next_irq_mask = hwdata[7:0] & `OSC_EVENT_MASK;
        end
        I_ISTS: begin
          irq_clr = hwdata[7:0];
        end
        default: begin
          next_force_on = force_on;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_on               <= `OSC_ENABLE_RESET;
      hf_freq_code           <= `OSC_FREQ_RESET;
      hf_trim_code           <= `OSC_TRIM_RESET;
      secondary_power_select <= 1'b0;
      irq_mask               <= '0;
    end else begin
      force_on               <= next_force_on;
      hf_freq_code           <= next_freq;
      hf_trim_code           <= next_trim;
      secondary_power_select <= next_pwr;
      irq_mask               <= next_irq_mask;
    end
  end

  // Oscillator run requests; high internal also runs whenever mid internal runs
  always_comb begin
    next_ext_run  = force_on[`OSC_EXT_BIT] | ext_osc_req;
    next_mf_run   = force_on[`OSC_MF_BIT] | mf_int_req;
    next_hf_run   = force_on[`OSC_HF_BIT] | hf_int_req | next_mf_run;
    next_lf_run   = force_on[`OSC_LF_BIT] | lf_int_req;
    next_sec_run  = force_on[`OSC_SEC_BIT] | secondary_req;
    next_conv_run = force_on[`OSC_CONV_BIT] | converter_osc_req;
    next_mode     = ext_osc_mode_config;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_osc_run       <= 1'b0;
      hf_int_run        <= 1'b0;
      mf_int_run        <= 1'b0;
      lf_int_run        <= 1'b0;
      secondary_run     <= 1'b0;
      converter_osc_run <= 1'b0;
      ext_osc_mode      <= '0;
    end else begin
      ext_osc_run       <= next_ext_run;
      hf_int_run        <= next_hf_run;
      mf_int_run        <= next_mf_run;
      lf_int_run        <= next_lf_run;
      secondary_run     <= next_sec_run;
      converter_osc_run <= next_conv_run;
      ext_osc_mode      <= next_mode;
    end
  end

  // Ready flags count only while the oscillator is running
  always_comb begin
    next_status                = '0;
    next_status[`OSC_EXT_BIT]  = ext_osc_run & rdy_s[6];
    next_status[`OSC_HF_BIT]   = hf_int_run & rdy_s[5];
    next_status[`OSC_MF_BIT]   = mf_int_run & rdy_s[4];
    next_status[`OSC_LF_BIT]   = lf_int_run & rdy_s[3];
    next_status[`OSC_SEC_BIT]  = secondary_run & rdy_s[2];
    next_status[`OSC_CONV_BIT] = converter_osc_run & rdy_s[1];
    // PLL source is the external oscillator; its flag lags that one by an edge
    next_status[`OSC_PLL_BIT]  = pll_enable & status[`OSC_EXT_BIT] & rdy_s[0];
  end

  // Status is rebuilt every cycle, so bus writes never reach it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // Rising ready flags raise sticky events; bit 1 has no oscillator and stays 0
  assign irq_set = next_status & ~status;

  // A hardware set in the clearing cycle wins over the clear
  osc_sticky_flags #(
    .W (8)
  ) u_events (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .set        (irq_set),
    .clr        (irq_clr),
    .flags      (irq_flags),
    .next_flags (next_irq_flags)
  );

  always_comb begin
    next_irq = |(next_irq_flags & next_irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Read word from the values that commit this edge, so a read right behind
  // a write to the same register returns the new contents
  always_comb begin
    rd_word = '0;
    case (a_idx)
      I_STAT:  rd_word[7:0] = next_status;
      I_EN:    rd_word[7:0] = next_force_on;
      I_TUNE:  rd_word[`OSC_TRIM_W-1:0] = next_trim;
      I_FREQ:  rd_word[`OSC_FREQ_W-1:0] = next_freq;
      I_PWR:   rd_word[`OSC_SEC_PWR_BIT] = next_pwr;
      I_ISTS:  rd_word[7:0] = next_irq_flags;
      I_IMSK:  rd_word[7:0] = next_irq_mask;
      default: rd_word = '0;
    endcase
  end

  // Bus phases; zero wait states and every response is OKAY
  always_comb begin
    next_dphase    = dp_none;
    next_dp_idx    = dp_idx;
    next_hrdata    = hrdata;
    next_hreadyout = 1'b1;
    next_hresp     = 1'b0;
    if (aphase) begin
      next_dp_idx = a_idx;
      if (hwrite) begin
        next_dphase = (hsize == `OSC_HSIZE_WORD) ? dp_write : dp_none;
      end else begin
        next_dphase = dp_read;
        next_hrdata = rd_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase    <= dp_none;
      dp_idx    <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dphase    <= next_dphase;
      dp_idx    <= next_dp_idx;
      hrdata    <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp     <= next_hresp;
    end
  end

endmodule

/* testbench/osc_ctrl_asserts.sv */
`timescale 1ns/100ps
module osc_ctrl_asserts (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Peripheral requests
  input wire logic       ext_osc_req,
  input wire logic       hf_int_req,
  input wire logic       mf_int_req,
  input wire logic       lf_int_req,
  input wire logic       secondary_req,
  input wire logic       converter_osc_req,
  // Oscillator controls
  input wire logic       ext_osc_run,
  input wire logic       hf_int_run,
  input wire logic       mf_int_run,
  input wire logic       lf_int_run,
  input wire logic       secondary_run,
  input wire logic       converter_osc_run,
  input wire logic [3:0] hf_freq_code,
  input wire logic [5:0] hf_trim_code
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ext_req_run: assert property (ext_osc_req |=> ext_osc_run)
    else $error("ext run missing");
  chk_hf_req_run: assert property (hf_int_req |-> ##1 hf_int_run)
    else $error("hf run missing");
  chk_mf_req_run: assert property (mf_int_req |=> mf_int_run)
    else $error("mf run missing");
  chk_mf_needs_hf: assert property (mf_int_run |-> hf_int_run)
    else $error("mf runs without hf");
  chk_lf_req_run: assert property ($rose(lf_int_req) |=> lf_int_run)
    else $error("lf run missing");
  chk_sec_req_run: assert property (secondary_req [*2] |-> secondary_run)
    else $error("secondary run missing");
  chk_conv_req_run: assert property (converter_osc_req |=> converter_osc_run)
    else $error("converter run missing");
  chk_freq_legal: assert property (hf_freq_code <= 4'h8)
    else $error("reserved freq code");
  chk_reset_dflt: assert property ($rose(hresetn) |-> hf_trim_code == 6'h00)
    else $error("trim default wrong");
endmodule
bind osc_ready_enable_freq_ctrl osc_ctrl_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
  .ext_osc_req(ext_osc_req), .hf_int_req(hf_int_req), .mf_int_req(mf_int_req),
  .lf_int_req(lf_int_req), .secondary_req(secondary_req),
  .converter_osc_req(converter_osc_req), .ext_osc_run(ext_osc_run),
  .hf_int_run(hf_int_run), .mf_int_run(mf_int_run), .lf_int_run(lf_int_run),
  .secondary_run(secondary_run), .converter_osc_run(converter_osc_run),
  .hf_freq_code(hf_freq_code), .hf_trim_code(hf_trim_code));

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`include "osc_ctrl_defines.svh"
module tb_top;
  import osc_ctrl_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lock = 0, pll_en = 0;
  logic        hreadyout, hresp, irq, pwr_o, b;
  logic [15:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2, mode = '0, mode_o;
  logic [31:0] hwdata = '0, hrdata, wd;
  logic [5:0]  reqv = '0, rawv = '0, runv, trim_o;
  logic [3:0]  freq_o, fm = 4'h2;
  logic [7:0]  en_m = '0, stat_m = '0, evt_m = '0;
  logic [5:0]  trims [3] = '{6'h1F, 6'h20, 6'h00};
  int          n_fail = 0, checks_done = 0;

  always #2.5 hclk = ~hclk;

  osc_ready_enable_freq_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_osc_ready_raw(rawv[5]),
    .hf_int_ready_raw(rawv[4]), .mf_int_ready_raw(rawv[3]), .lf_int_ready_raw(rawv[2]),
    .secondary_ready_raw(rawv[1]), .converter_ready_raw(rawv[0]), .pll_lock_raw(lock),
    .ext_osc_req(reqv[5]), .hf_int_req(reqv[4]), .mf_int_req(reqv[3]), .lf_int_req(reqv[2]),
    .secondary_req(reqv[1]), .converter_osc_req(reqv[0]), .pll_enable(pll_en),
    .ext_osc_mode_config(mode), .ext_osc_run(runv[5]), .hf_int_run(runv[4]),
    .mf_int_run(runv[3]), .lf_int_run(runv[2]), .secondary_run(runv[1]),
    .converter_osc_run(runv[0]), .ext_osc_mode(mode_o), .secondary_power_select(pwr_o),
    .hf_freq_code(freq_o), .hf_trim_code(trim_o), .irq(irq));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic [11:0] idx, input logic wr, input logic [2:0] sz,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr <= {2'b00, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    hsel <= 1'b1;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(idx, 1'b1, 3'h2, d, q);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    bus(idx, 1'b0, 3'h2, 32'h0, q);
    chk(nm, exp, q);
  endtask

  function automatic logic [5:0] exp_run();
    logic [5:0] x;
    x = en_m[7:2] | reqv;
    x[4] = x[4] | x[3];
    return x;
  endfunction

  // Let one cause propagate, then track status rises as events
  task automatic settle();
    logic [7:0] ns;
    logic [5:0] x;
    repeat (6) @(posedge hclk);
    #1;
    x = exp_run();
    ns = {x & rawv, 1'b0, pll_en & x[5] & rawv[5] & lock};
    evt_m = evt_m | (ns & ~stat_m);
    stat_m = ns;
    chk("run", exp_run(), runv);
  endtask

  task automatic final_report();
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #50000;
    n_fail++;
    final_report();
  end

  initial begin
    void'($urandom(32'h09395D01));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`OSC_ENABLE_IDX, 32'h0, "enable_rst");
    rd(`OSC_TUNE_IDX, 32'h0, "trim_rst");
    rd(`OSC_STATUS_IDX, 32'h0, "status_rst");
    rd(`OSC_FREQ_IDX, 32'h2, "freq_rst");
    rd(`OSC_PWR_IDX, 32'h0, "power_rst");
    wr(12'hED0, 32'hFF);
    rd(12'hED0, 32'h0, "unmapped");
    for (int i = 0; i < 24; i++) begin
      wd = (i < 6) ? 32'h80 >> i : $urandom;
      en_m = wd[7:0] & 8'hFC;
      wr(`OSC_ENABLE_IDX, wd);
      settle();
      rd(`OSC_ENABLE_IDX, en_m, "enable");
      @(posedge hclk);
      reqv <= (i < 6) ? 6'h0 : 6'($urandom);
      mode <= 3'($urandom);
      settle();
      chk("mode", mode, mode_o);
      // Lock and PLL enable move alone, so the PLL flag never pulses between checks
      @(posedge hclk);
      lock <= 1'($urandom);
      settle();
      @(posedge hclk);
      pll_en <= 1'($urandom);
      settle();
      @(posedge hclk);
      rawv <= 6'($urandom);
      settle();
      wr(`OSC_STATUS_IDX, $urandom);
      chk("resp", 32'h0, hresp);
      rd(`OSC_STATUS_IDX, stat_m, "status");
      rd(`OSC_IRQ_STAT_IDX, evt_m, "events");
      wd = $urandom;
      wr(`OSC_IRQ_STAT_IDX, wd);
      evt_m = evt_m & ~wd[7:0];
    end
    en_m = 8'hFC;
    wr(`OSC_ENABLE_IDX, 32'hFC);
    @(posedge hclk);
    rawv <= 6'h00;
    settle();
    @(posedge hclk);
    rawv <= 6'h3F;
    settle();
    wr(`OSC_IRQ_MASK_IDX, 32'h0);
    repeat (2) @(posedge hclk);
    #1 b = irq;
    wr(`OSC_IRQ_MASK_IDX, 32'hFF);
    rd(`OSC_IRQ_MASK_IDX, 32'hFD, "mask");
    #1 chk("irq_masked", 32'h0, b);
    chk("irq_mask", evt_m != 0, irq);
    wr(`OSC_IRQ_STAT_IDX, 32'hFF);
    repeat (2) @(posedge hclk);
    #1 chk("irq_clear", 0, irq);
    for (int c = 0; c < 16; c++) begin
      wr(`OSC_FREQ_IDX, c);
      if (c <= 8) fm = 4'(c);
      rd(`OSC_FREQ_IDX, fm, "freq");
      chk("freq_out", fm, freq_o);
    end
    wr(`OSC_FREQ_IDX, 32'hFFFFFFF5);
    fm = 4'h5;
    rd(`OSC_FREQ_IDX, fm, "freq_upper");
    foreach (trims[k]) begin
      wr(`OSC_TUNE_IDX, {26'h3, trims[k]});
      rd(`OSC_TUNE_IDX, trims[k], "trim");
      chk("trim_out", trims[k], trim_o);
    end
    for (int p = 0; p < 2; p++) begin
      wr(`OSC_PWR_IDX, p ? 32'hBF : 32'h40);
      rd(`OSC_PWR_IDX, p ? 32'h0 : 32'h40, "power");
      chk("power_out", !p, pwr_o);
    end
    // Reset again in mid-run: every register and flag returns to its reset state
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    en_m = '0;
    stat_m = '0;
    evt_m = '0;
    settle();
    rd(`OSC_ENABLE_IDX, 32'h0, "enable_rst2");
    rd(`OSC_FREQ_IDX, 32'h2, "freq_rst2");
    rd(`OSC_STATUS_IDX, stat_m, "status_rst2");
    rd(`OSC_IRQ_STAT_IDX, evt_m, "events_rst2");
    final_report();
  end
endmodule
